// ==== verilog/efs_dev.sv ====
`timescale 1ns/100ps
`default_nettype none
module efs_dev
    import efs_pkg::*;
#(
    parameter int SAMPLE_CYC = EFS_SAMPLE_CYC
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    efs_link_if.dev link,
    input wire logic active_mode_i,
    input wire logic drift_long_i,
    input wire logic pkt_vld_i,
    input wire logic [15:0] pkt_word_i,
    output logic pkt_rdy_o,
    output logic frame_tick_o,
    output logic [7:0] frame_len_o,
    output logic slip_seen_o
);
    // scnt is 16 bits wide
    if (SAMPLE_CYC < 2 || SAMPLE_CYC > 65536) begin : g_bad_cyc
        $error("SAMPLE_CYC out of range");
    end
    typedef enum logic [2:0] {
        EFS_FILL = 3'b001,
        EFS_WAIT = 3'b010,
        EFS_SEND = 3'b100
    } efs_st_t;
    ////////////////////////////////////////////////////////////////////
    // transmit buffer: header, data words, terminator
    logic [15:0] tx_buf [0:EFS_PKT_WORDS];
    logic [15:0] next_buf_w;
    logic [4:0] wptr, next_wptr, rptr, next_rptr;
    logic ready, next_ready;
    efs_st_t st, next_st;
    logic [15:0] rd_data, next_rd_data;
    logic rd_vld, next_rd_vld;
    logic we;
    logic term_left, next_term_left;
    logic pkt_rdy, next_pkt_rdy;
    always_comb begin
        next_wptr = wptr;
        next_rptr = rptr;
        next_ready = ready;
        next_term_left = term_left;
        next_st = st;
        next_rd_vld = link.rd_req;
        next_rd_data = rd_data;
        we = 1'b0;
        next_buf_w = pkt_word_i;
        case (st)
            EFS_FILL: begin
                if (pkt_vld_i) begin
                    we = 1'b1;
                    next_buf_w = (wptr == 5'd0) ? EFS_HEADER : pkt_word_i;
                    next_wptr = wptr + 5'd1;
                    if (wptr == 5'(EFS_DATA_WORDS)) next_st = EFS_WAIT;
                end
            end
            EFS_WAIT: begin
                // terminator closes the packet
                we = 1'b1;
                next_buf_w = EFS_TERM;
                next_st = EFS_SEND;
            end
            EFS_SEND: begin
                if (frame_tick_o) begin
                    next_ready = 1'b1;
                    next_rptr = 5'd0;
                    next_st = EFS_FILL;
                    next_wptr = 5'd0;
                end
            end
            default: next_st = EFS_FILL;
        endcase
        if (link.rd_req) begin
            // stale words survive a short read
            // terminator of the last packet goes out before the header
            if (!ready || term_left) begin
                next_rd_data = EFS_TERM;
                next_term_left = 1'b0;
            end else begin
                next_rd_data = tx_buf[rptr];
                next_rptr = rptr + 5'd1;
                if (rptr == 5'(EFS_DATA_WORDS)) begin
                    next_ready = 1'b0;
                    next_term_left = 1'b1;
                end
            end
        end
        next_pkt_rdy = (next_st == EFS_FILL) ? 1'b1 : 1'b0;
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wptr <= 5'd0;
            rptr <= 5'd0;
            ready <= 1'b0;
            st <= EFS_FILL;
            rd_vld <= 1'b0;
            rd_data <= EFS_TERM;
            term_left <= 1'b1;
            pkt_rdy <= 1'b1;
        end else begin
            wptr <= next_wptr;
            rptr <= next_rptr;
            ready <= next_ready;
            st <= next_st;
            rd_vld <= next_rd_vld;
            rd_data <= next_rd_data;
            term_left <= next_term_left;
            pkt_rdy <= next_pkt_rdy;
        end
    end
    always_ff @(posedge clk_i) begin
        if (we) begin
            tx_buf[wptr] <= next_buf_w;
        end
    end
    assign link.rd_vld = rd_vld;
    assign link.rd_data = rd_data;
    ////////////////////////////////////////////////////////////////////
    // slip packet detection on decoder input
    logic [4:0] in_idx, next_in_idx;
    logic in_match, next_in_match;
    logic slip_pend, next_slip_pend;
    logic [2:0] sync_en;
    logic en_q, next_en_q;
    always_comb begin
        next_in_idx = in_idx;
        next_in_match = in_match;
        next_slip_pend = slip_pend;
        // only the last two stages decide, the first may be metastable
        next_en_q = (sync_en[2] == sync_en[1]) ? sync_en[2] : en_q;
        // clear first so a new packet in the same cycle wins
        if (frame_tick_o && frame_len_o == 8'(EFS_FRAME_SHORT))
            next_slip_pend = 1'b0;
        if (link.wr_vld) begin
            next_in_idx = (in_idx == 5'(EFS_DATA_WORDS)) ? 5'd0 : in_idx + 5'd1;
            case (in_idx)
                5'd0: next_in_match = (link.wr_data == EFS_HEADER);
                5'd1: next_in_match = in_match
                    & (link.wr_data[15:8] == EFS_SLIP_ID);
                5'd2: next_in_match = in_match
                    & (link.wr_data == EFS_SLIP_IND);
                5'd3: next_in_match = in_match
                    & (link.wr_data == EFS_SLIP_DATA);
                default: begin
                    if (in_idx <= 5'(EFS_ZERO_LAST))
                        next_in_match = in_match
                            & (link.wr_data == EFS_ZERO);
                end
            endcase
            if (in_idx == 5'(EFS_ZERO_LAST) && in_match
                && link.wr_data == EFS_ZERO && en_q && !active_mode_i)
                next_slip_pend = 1'b1;
        end
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            in_idx <= 5'd0;
            in_match <= 1'b0;
            slip_pend <= 1'b0;
            sync_en <= 3'b000;
            en_q <= 1'b0;
        end else begin
            in_idx <= next_in_idx;
            in_match <= next_in_match;
            slip_pend <= next_slip_pend;
            sync_en <= {sync_en[1:0], link.slip_en};
            en_q <= next_en_q;
        end
    end
    ////////////////////////////////////////////////////////////////////
    // frame timing: 160/161, or 159 after a slip packet
    logic [15:0] scnt, next_scnt;
    logic [7:0] samp, next_samp, len, next_len;
    logic tick, next_tick, seen, next_seen;
    always_comb begin
        next_scnt = scnt + 16'd1;
        next_samp = samp;
        next_len = len;
        next_tick = 1'b0;
        next_seen = seen;
        if (scnt == 16'(SAMPLE_CYC - 1)) begin
            next_scnt = 16'd0;
            next_samp = samp + 8'd1;
            if (samp == len - 8'd1) begin
                next_samp = 8'd0;
                next_tick = 1'b1;
                if (!en_q || active_mode_i)
                    next_len = 8'(EFS_FRAME_NOM);
                else if (slip_pend)
                    next_len = 8'(EFS_FRAME_SHORT);
                else
                    next_len = drift_long_i ? 8'(EFS_FRAME_LONG)
                        : 8'(EFS_FRAME_NOM);
                next_seen = slip_pend;
            end
        end
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            scnt <= 16'd0;
            samp <= 8'd0;
            len <= 8'(EFS_FRAME_NOM);
            tick <= 1'b0;
            seen <= 1'b0;
        end else begin
            scnt <= next_scnt;
            samp <= next_samp;
            len <= next_len;
            tick <= next_tick;
            seen <= next_seen;
        end
    end
    assign frame_tick_o = tick;
    assign frame_len_o = len;
    assign slip_seen_o = seen;
    assign pkt_rdy_o = pkt_rdy;
endmodule : efs_dev
`default_nettype wire

// ==== verilog/efs_pkg.sv ====
// Functional notes
// - host raises slip enable for async passive channels
// - active mode: device times channel, no slip
// - voice frames nominally twenty milliseconds long
// - slip enabled: frames of 160 or 161 samples
// - internal 0.6 percent, host-assisted 1.2 percent
// - slip packets widen range to 159..161
// - buffer gets header, 23 words, terminator
// - leftover terminator is first word out
// - terminator until ready, then 24-word packet
// - short reads leave stale words for later
// - host reads to header, then 23 more
// - slip packet words 0..3 fixed layout
// - slip packet words 4..11 zero, rest voice
// - host keeps interval times rate within 160..161
// - periodic method: one slip packet per N frames
// - as-needed reads every 19.875..20.125 ms
// - two or more terminators: send slip packet
// - slip packet advances readiness 125 us
// - host buffers late packets up to 125 us
package efs_pkg;
    localparam logic [15:0] EFS_HEADER = 16'h13ec;
    localparam logic [15:0] EFS_TERM = 16'hfffe;
    localparam logic [7:0] EFS_SLIP_ID = 8'h07;
    localparam logic [15:0] EFS_SLIP_IND = 16'h12c9;
    localparam logic [15:0] EFS_SLIP_DATA = 16'h009f;
    localparam logic [15:0] EFS_ZERO = 16'h0000;
    localparam int EFS_DATA_WORDS = 23;
    localparam int EFS_PKT_WORDS = 24;
    localparam int EFS_ZERO_LAST = 11;
    localparam int EFS_FRAME_NOM = 160;
    localparam int EFS_FRAME_LONG = 161;
    localparam int EFS_FRAME_SHORT = 159;
    // sample period 125 us at 8 kHz
    localparam int EFS_SAMPLE_NS = 125000;
    localparam int EFS_CLK_NS = 4;
    localparam int EFS_SAMPLE_CYC = EFS_SAMPLE_NS / EFS_CLK_NS;
    localparam int EFS_FRAME_MS = 20;
endpackage : efs_pkg

// ==== verilog/efs_link_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface efs_link_if;
    logic rd_req;
    logic rd_vld;
    logic [15:0] rd_data;
    logic wr_vld;
    logic [15:0] wr_data;
    logic slip_en;
    modport dev (input rd_req, output rd_vld, output rd_data,
        input wr_vld, input wr_data, input slip_en);
    modport host (output rd_req, input rd_vld, input rd_data,
        output wr_vld, output wr_data, output slip_en);
endinterface : efs_link_if
`default_nettype wire

// ==== verilog/efs_host.sv ====
`timescale 1ns/100ps
`default_nettype none
module efs_host
    import efs_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    efs_link_if.host link,
    input wire logic slip_en_i,
    input wire logic read_start_i,
    output logic word_vld_o,
    output logic [15:0] word_o,
    output logic pkt_done_o,
    output logic slip_sent_o
);
    typedef enum logic [3:0] {
        EFS_IDLE = 4'b0001,
        EFS_HUNT = 4'b0010,
        EFS_BODY = 4'b0100,
        EFS_SLIP = 4'b1000
    } efs_hst_t;
    efs_hst_t st, next_st;
    logic req, next_req, busy, next_busy;
    logic [4:0] cnt, next_cnt;
    logic [1:0] terms, next_terms;
    logic need, next_need;
    logic wv, next_wv, done, next_done, sent, next_sent;
    logic [15:0] wd, next_wd, ww, next_ww;
    logic en, next_en;
    // fixed slip packet image, voice words left zero here
    function automatic logic [15:0] slip_word(input logic [4:0] i);
        case (i)
            5'd0: slip_word = EFS_HEADER;
            5'd1: slip_word = {EFS_SLIP_ID, 8'h00};
            5'd2: slip_word = EFS_SLIP_IND;
            5'd3: slip_word = EFS_SLIP_DATA;
            default: slip_word = EFS_ZERO;
        endcase
    endfunction : slip_word
    always_comb begin
        next_st = st;
        next_req = 1'b0;
        next_busy = busy;
        next_cnt = cnt;
        next_terms = terms;
        next_need = need;
        next_wv = 1'b0;
        next_wd = wd;
        next_done = 1'b0;
        next_sent = 1'b0;
        next_ww = ww;
        next_en = slip_en_i;
        case (st)
            EFS_IDLE: begin
                if (read_start_i) begin
                    next_st = EFS_HUNT;
                    next_terms = 2'd0;
                    next_req = 1'b1;
                    next_busy = 1'b1;
                end else if (need) begin
                    next_st = EFS_SLIP;
                    next_cnt = 5'd0;
                end
            end
            EFS_HUNT: begin
                // late packet: terminators absorbed while polling
                next_req = !busy;
                if (link.rd_vld) begin
                    next_busy = 1'b0;
                    if (link.rd_data == EFS_HEADER) begin
                        next_st = EFS_BODY;
                        next_cnt = 5'd0;
                        next_wv = 1'b1;
                        next_wd = link.rd_data;
                        if (terms >= 2'd2 && en)
                            next_need = 1'b1;
                    end else if (link.rd_data == EFS_TERM && terms != 2'd3)
                        next_terms = terms + 2'd1;
                end else if (!busy) next_busy = 1'b1;
            end
            EFS_BODY: begin
                next_req = !busy;
                if (!busy) next_busy = 1'b1;
                if (link.rd_vld) begin
                    next_busy = 1'b0;
                    next_wv = 1'b1;
                    next_wd = link.rd_data;
                    next_cnt = cnt + 5'd1;
                    if (cnt == 5'(EFS_DATA_WORDS - 1)) begin
                        next_st = EFS_IDLE;
                        next_done = 1'b1;
                        next_req = 1'b0;
                    end
                end
            end
            EFS_SLIP: begin
                next_ww = slip_word(cnt);
                next_cnt = cnt + 5'd1;
                if (cnt == 5'(EFS_DATA_WORDS)) begin
                    next_st = EFS_IDLE;
                    next_need = 1'b0;
                    next_sent = 1'b1;
                end
            end
            default: next_st = EFS_IDLE;
        endcase
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st <= EFS_IDLE;
            req <= 1'b0;
            busy <= 1'b0;
            cnt <= 5'd0;
            terms <= 2'd0;
            need <= 1'b0;
            wv <= 1'b0;
            wd <= 16'h0000;
            done <= 1'b0;
            sent <= 1'b0;
            ww <= 16'h0000;
            en <= 1'b0;
        end else begin
            st <= next_st;
            req <= next_req;
            busy <= next_busy;
            cnt <= next_cnt;
            terms <= next_terms;
            need <= next_need;
            wv <= next_wv;
            wd <= next_wd;
            done <= next_done;
            sent <= next_sent;
            ww <= next_ww;
            en <= next_en;
        end
    end
    logic wvld;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) wvld <= 1'b0;
        else wvld <= (st == EFS_SLIP);
    end
    assign link.rd_req = req;
    assign link.wr_vld = wvld;
    assign link.wr_data = ww;
    assign link.slip_en = en;
    assign word_vld_o = wv;
    assign word_o = wd;
    assign pkt_done_o = done;
    assign slip_sent_o = sent;
endmodule : efs_host
`default_nettype wire

// ==== dv/efs_monitor.sv ====
`timescale 1ns/100ps
`default_nettype none
module efs_monitor
    import efs_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic rd_req,
    input wire logic rd_vld,
    input wire logic [15:0] rd_data,
    input wire logic wr_vld,
    input wire logic [15:0] wr_data,
    input wire logic slip_en
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    ////////////////////////////////////////////////////////////////////////
    // words answered since the header; 24 means the packet was read whole
    logic [4:0] wcnt;
    logic [4:0] next_wcnt;
    always_comb begin
        next_wcnt = wcnt;
        if (rd_vld) begin
            if (wcnt == 5'd0 && rd_data == EFS_HEADER) next_wcnt = 5'd1;
            else if (wcnt == 5'd24) next_wcnt = 5'd0;
            else if (wcnt != 5'd0) next_wcnt = wcnt + 5'd1;
        end
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) wcnt <= 5'd0;
        else wcnt <= next_wcnt;
    end
    ////////////////////////////////////////////////////////////////////////
    sequence s_wr_start;
        !wr_vld ##1 wr_vld;
    endsequence
    sequence s_slip_head;
        wr_data[15:8] == EFS_SLIP_ID ##1 wr_data == EFS_SLIP_IND
            ##1 wr_data == EFS_SLIP_DATA;
    endsequence
    property p_answer;
        rd_req |=> rd_vld;
    endproperty
    property p_no_spurious;
        rd_vld |-> $past(rd_req);
    endproperty
    property p_hold;
        !rd_vld |-> $stable(rd_data);
    endproperty
    property p_term_after;
        rd_vld && wcnt == 5'd24 |-> rd_data == EFS_TERM;
    endproperty
    property p_hdr_next;
        rd_vld && rd_data == EFS_HEADER && wcnt == 5'd0 |-> ##[1:3] rd_req;
    endproperty
    property p_slip_hdr;
        s_wr_start |-> wr_data == EFS_HEADER ##1 s_slip_head;
    endproperty
    property p_slip_zero;
        s_wr_start ##4 1'b1 |-> (wr_data == EFS_ZERO) [*8];
    endproperty
    property p_slip_len;
        s_wr_start |-> ##23 wr_vld ##1 !wr_vld;
    endproperty
    property p_slip_en;
        s_wr_start |-> slip_en;
    endproperty
    a_answer: assert property (p_answer)
        else $error("read not answered next cycle");
    a_no_spurious: assert property (p_no_spurious)
        else $error("answer without request");
    a_hold: assert property (p_hold)
        else $error("read data moved without answer");
    a_term_after: assert property (p_term_after)
        else $error("no terminator after full packet");
    a_hdr_next: assert property (p_hdr_next)
        else $error("host stopped after header");
    a_slip_hdr: assert property (p_slip_hdr)
        else $error("slip packet head wrong");
    a_slip_zero: assert property (p_slip_zero)
        else $error("slip packet words 4..11 not zero");
    a_slip_len: assert property (p_slip_len)
        else $error("slip packet not 24 words");
    a_slip_en: assert property (p_slip_en)
        else $error("slip packet with slip disabled");
endmodule : efs_monitor
`default_nettype wire

// ==== dv/efs_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module testbench
    import efs_pkg::*;
;
    logic clk_i, rst_n_i, active_mode_i, drift_long_i, pkt_vld_i;
    logic slip_en_i, read_start_i;
    logic [15:0] pkt_word_i;
    logic pkt_rdy_o, frame_tick_o, slip_seen_o;
    logic word_vld_o, pkt_done_o, slip_sent_o;
    logic [7:0] frame_len_o;
    logic [15:0] word_o;
    logic [7:0] lo, hi;
    logic seen_any;
    int error_cnt, checked, terms;
    efs_link_if link();
    efs_dev #(.SAMPLE_CYC(4)) u_efs_dev (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .link(link), .active_mode_i(active_mode_i),
        .drift_long_i(drift_long_i), .pkt_vld_i(pkt_vld_i),
        .pkt_word_i(pkt_word_i), .pkt_rdy_o(pkt_rdy_o),
        .frame_tick_o(frame_tick_o), .frame_len_o(frame_len_o),
        .slip_seen_o(slip_seen_o));
    efs_host u_efs_host (.clk_i(clk_i), .rst_n_i(rst_n_i), .link(link),
        .slip_en_i(slip_en_i), .read_start_i(read_start_i),
        .word_vld_o(word_vld_o), .word_o(word_o), .pkt_done_o(pkt_done_o),
        .slip_sent_o(slip_sent_o));
    efs_monitor u_efs_monitor (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .rd_req(link.rd_req), .rd_vld(link.rd_vld), .rd_data(link.rd_data),
        .wr_vld(link.wr_vld), .wr_data(link.wr_data),
        .slip_en(link.slip_en));
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    task test_done;
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : test_done
    task hang;
        error_cnt++;
        $display("wrong value at %0t: wait ran out", $time);
        test_done();
    endtask : hang
    task check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %h not %h", $time, seen, exp);
        end
    endtask : check
    task automatic wait_tick;
        int n;
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
        end while (frame_tick_o !== 1'b1 && n < 3000);
        if (n >= 3000) hang();
    endtask : wait_tick
    task automatic scan(input int nf);
        lo = 8'hff;
        hi = 8'h00;
        seen_any = 1'b0;
        for (int k = 0; k < nf; k++) begin
            wait_tick();
            if (slip_seen_o === 1'b1) seen_any = 1'b1;
            if (frame_len_o < lo) lo = frame_len_o;
            if (frame_len_o > hi) hi = frame_len_o;
        end
    endtask : scan
    // first encoder word is overwritten by the header inside the device
    task automatic fill(input logic [15:0] base);
        int n;
        n = 0;
        while (pkt_rdy_o !== 1'b1 && n < 4000) begin
            @(negedge clk_i);
            n++;
        end
        if (n >= 4000) hang();
        for (int i = 0; i < EFS_PKT_WORDS; i++) begin
            pkt_vld_i = 1'b1;
            pkt_word_i = base + 16'(i);
            @(negedge clk_i);
        end
        pkt_vld_i = 1'b0;
    endtask : fill
    task automatic read_pkt(input logic [15:0] base);
        int n, got;
        bit hdr, done;
        terms = 0;
        got = 0;
        hdr = 0;
        done = 0;
        read_start_i = 1'b1;
        @(negedge clk_i);
        read_start_i = 1'b0;
        for (n = 0; n < 5000 && !done; n++) begin
            if (link.rd_vld === 1'b1) begin
                if (hdr) begin
                    check(link.rd_data, base + 16'(got + 1));
                    got++;
                end else if (link.rd_data === EFS_TERM) terms++;
                else begin
                    check(link.rd_data, EFS_HEADER);
                    hdr = 1;
                end
            end
            if (pkt_done_o === 1'b1) done = 1;
            else @(negedge clk_i);
        end
        if (!done) hang();
        check(16'(got), 16'(EFS_DATA_WORDS));
        check(16'(word_vld_o), 16'h0001);
        check(word_o, base + 16'(EFS_DATA_WORDS));
    endtask : read_pkt
    ////////////////////////////////////////////////////////////////////////
    task t_reset;
        check(link.rd_data, EFS_TERM);
        check({8'h00, frame_len_o}, 16'(EFS_FRAME_NOM));
        $display("test reset done");
    endtask : t_reset
    task t_read;
        wait_tick();
        fill(16'h0100);
        read_pkt(16'h0100);
        check(16'(terms > 1), 16'h0001);
        fill(16'h0200);
        wait_tick();
        read_pkt(16'h0200);
        check(16'(terms), 16'h0001);
        $display("test read done");
    endtask : t_read
    task t_fixed;
        drift_long_i = 1'b1;
        scan(3);
        check({8'h00, lo}, 16'(EFS_FRAME_NOM));
        check({8'h00, hi}, 16'(EFS_FRAME_NOM));
        check(16'(seen_any), 16'h0000);
        $display("test fixed done");
    endtask : t_fixed
    task t_long;
        slip_en_i = 1'b1;
        scan(2);
        scan(3);
        check({8'h00, hi}, 16'(EFS_FRAME_LONG));
        check(16'(lo >= 8'(EFS_FRAME_NOM)), 16'h0001);
        $display("test long done");
    endtask : t_long
    task t_active;
        active_mode_i = 1'b1;
        scan(2);
        scan(3);
        check({8'h00, lo}, 16'(EFS_FRAME_NOM));
        check({8'h00, hi}, 16'(EFS_FRAME_NOM));
        active_mode_i = 1'b0;
        drift_long_i = 1'b0;
        $display("test active done");
    endtask : t_active
    task automatic t_slip;
        int n;
        scan(2);
        fill(16'h0300);
        read_pkt(16'h0300);
        check(16'(terms > 1), 16'h0001);
        n = 0;
        while (slip_sent_o !== 1'b1 && n < 3000) begin
            @(negedge clk_i);
            n++;
        end
        if (n >= 3000) hang();
        scan(3);
        check({8'h00, lo}, 16'(EFS_FRAME_SHORT));
        check(16'(seen_any), 16'h0001);
        $display("test slip done");
    endtask : t_slip
    initial begin
        error_cnt = 0;
        checked = 0;
        rst_n_i = 1'b0;
        active_mode_i = 1'b0;
        drift_long_i = 1'b0;
        pkt_vld_i = 1'b0;
        pkt_word_i = 16'h0000;
        slip_en_i = 1'b0;
        read_start_i = 1'b0;
        repeat (8) @(negedge clk_i);
        rst_n_i = 1'b1;
        @(negedge clk_i);
        t_reset();
        t_read();
        t_fixed();
        t_long();
        t_active();
        t_slip();
        test_done();
    end
endmodule : testbench
`default_nettype wire
